/* File: nor_seq_pkg.sv */
// Purpose: Constants for the host-side NOR flash command sequencer
// Assumes: 16-bit word-mode device on an asynchronous address/data bus
// Notes: Command codes outside this set cannot be issued from the user port
package nor_seq_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CLK_HZ = 50000000;
  // Bus strobe timing
  localparam int WE_PULSE_NS = 60;
  localparam int RD_ACCESS_NS = 80;
  localparam int WE_PULSE_CYC = (WE_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RD_ACCESS_CYC =
    (RD_ACCESS_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CNT_W = 4;
  // Unlock cycles
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 23'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 23'h0002aa;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
  // Command codes
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
  localparam logic [DATA_W-1:0] CMD_ID_READ = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_BYPASS = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_BYPASS_RST1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_BYPASS_RST2 = 16'h0000;
  localparam logic [DATA_W-1:0] CMD_BUF_LOAD = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_BUF_CONFIRM = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_EXIT2 = 16'h0000;
  localparam logic [ADDR_W-1:0] QUERY_ADDR = 23'h000055;
  localparam logic [ADDR_W-1:0] QRY_SIG_ADDR = 23'h000010;
  localparam int BUF_WORDS_MAX = 32;
  localparam int BUF_SEQ_MAX_CYC = 37;
  // Operation codes at the user port
  localparam logic [3:0] OP_RESET = 4'h0;
  localparam logic [3:0] OP_ID_ENTER = 4'h1;
  localparam logic [3:0] OP_QUERY = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_READ = 4'h4;
  localparam logic [3:0] OP_BYPASS_ENTER = 4'h5;
  localparam logic [3:0] OP_BYPASS_PROG = 4'h6;
  localparam logic [3:0] OP_BYPASS_EXIT = 4'h7;
  localparam logic [3:0] OP_BUF_PROG = 4'h8;
  localparam logic [3:0] OP_SUSPEND = 4'h9;
  localparam logic [3:0] OP_RESUME = 4'ha;
  localparam logic [3:0] OP_SET_EXIT = 4'hb;
endpackage : nor_seq_pkg

/* File: nor_flash_command_sequencer.sv */
// Purpose: Host controller issuing NOR flash command sequences on pins
// Assumes: Device pins are asynchronous; read data synchronised in 3 stages
// Notes: One bus cycle at a time; busy while a sequence runs
`timescale 1ns/10ps
`default_nettype none
module nor_flash_command_sequencer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_op,
  input wire logic [22:0] req_addr,
  input wire logic [15:0] req_data,
  input wire logic [4:0] req_count,
  // Buffer word stream
  input wire logic buf_valid,
  output logic buf_ready,
  input wire logic [15:0] buf_data,
  // User answer
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [1:0] mode,
  // Flash pins
  output logic [22:0] flash_addr,
  output logic [15:0] dq_out,
  output logic dq_oe_n,
  input wire logic [15:0] dq_in,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_READ,
    S_DONE} state_t;
  localparam logic [1:0] MODE_ARRAY = 2'h0;
  localparam logic [1:0] MODE_ID = 2'h1;
  localparam logic [1:0] MODE_BYPASS = 2'h2;
  localparam logic [1:0] MODE_SUSP = 2'h3;

  state_t state_r;
  logic [5:0] step_r;
  logic [5:0] last_step_r;
  logic [3:0] op_r;
  logic [22:0] addr_r;
  logic [15:0] data_r;
  logic [4:0] count_r;
  logic [nor_seq_pkg::CNT_W-1:0] cnt_r;
  logic [15:0] sync1_r, sync2_r, sync3_r;
  logic [1:0] mode_r;
  logic cyc_read;
  logic [22:0] cyc_addr;
  logic [15:0] cyc_data;
  logic [5:0] seq_len;
  logic legal;

  ////////////////////////////////////////////////////////////////
  // Sequence tables
  always_comb begin
    seq_len = 6'd1;
    case (req_op)
      nor_seq_pkg::OP_RESET: seq_len = 6'd1;
      nor_seq_pkg::OP_ID_ENTER: seq_len = 6'd4;
      nor_seq_pkg::OP_QUERY: seq_len = 6'd1;
      nor_seq_pkg::OP_PROGRAM: seq_len = 6'd4;
      nor_seq_pkg::OP_READ: seq_len = 6'd1;
      nor_seq_pkg::OP_BYPASS_ENTER: seq_len = 6'd3;
      nor_seq_pkg::OP_BYPASS_PROG: seq_len = 6'd2;
      nor_seq_pkg::OP_BYPASS_EXIT: seq_len = 6'd2;
      nor_seq_pkg::OP_BUF_PROG: seq_len = 6'(req_count) + 6'd6;
      nor_seq_pkg::OP_SUSPEND: seq_len = 6'd1;
      nor_seq_pkg::OP_RESUME: seq_len = 6'd1;
      nor_seq_pkg::OP_SET_EXIT: seq_len = 6'd2;
      default: seq_len = 6'd1;
    endcase
  end

  // Refuse commands that the current mode does not admit
  always_comb begin
    legal = 1'b1;
    if (mode_r == MODE_BYPASS) begin
      legal = (req_op == nor_seq_pkg::OP_BYPASS_PROG) ||
        (req_op == nor_seq_pkg::OP_BYPASS_EXIT) ||
        (req_op == nor_seq_pkg::OP_READ);
    end else if (req_op == nor_seq_pkg::OP_BYPASS_PROG ||
        req_op == nor_seq_pkg::OP_BYPASS_EXIT) begin
      legal = 1'b0;
    end
    if (req_op == nor_seq_pkg::OP_RESUME && mode_r != MODE_SUSP) begin
      legal = 1'b0;
    end
    if (req_op == nor_seq_pkg::OP_BUF_PROG &&
        !(mode_r == MODE_ARRAY || mode_r == MODE_ID)) begin
      legal = 1'b0;
    end
  end

  // Address, data and direction of the current cycle
  always_comb begin
    cyc_read = 1'b0;
    cyc_addr = nor_seq_pkg::UNLOCK1_ADDR;
    cyc_data = nor_seq_pkg::UNLOCK1_DATA;
    case (op_r)
      nor_seq_pkg::OP_RESET: cyc_data = nor_seq_pkg::CMD_RESET;
      nor_seq_pkg::OP_QUERY: begin
        cyc_addr = nor_seq_pkg::QUERY_ADDR;
        cyc_data = nor_seq_pkg::CMD_QUERY;
      end
      nor_seq_pkg::OP_READ: begin
        cyc_read = 1'b1;
        cyc_addr = addr_r;
      end
      nor_seq_pkg::OP_SUSPEND: begin
        cyc_addr = addr_r;
        cyc_data = nor_seq_pkg::CMD_SUSPEND;
      end
      nor_seq_pkg::OP_RESUME: begin
        cyc_addr = addr_r;
        cyc_data = nor_seq_pkg::CMD_RESUME;
      end
      nor_seq_pkg::OP_SET_EXIT, nor_seq_pkg::OP_BYPASS_EXIT: begin
        cyc_addr = addr_r;
        cyc_data = (step_r == 6'd0) ? nor_seq_pkg::CMD_EXIT1 :
          nor_seq_pkg::CMD_EXIT2;
      end
      nor_seq_pkg::OP_BYPASS_PROG: begin
        cyc_addr = addr_r;
        cyc_data = (step_r == 6'd0) ? nor_seq_pkg::CMD_PROGRAM : data_r;
      end
      default: begin
        case (step_r)
          6'd0: begin
            cyc_addr = nor_seq_pkg::UNLOCK1_ADDR;
            cyc_data = nor_seq_pkg::UNLOCK1_DATA;
          end
          6'd1: begin
            cyc_addr = nor_seq_pkg::UNLOCK2_ADDR;
            cyc_data = nor_seq_pkg::UNLOCK2_DATA;
          end
          6'd2: begin
            cyc_addr = nor_seq_pkg::UNLOCK1_ADDR;
            case (op_r)
              nor_seq_pkg::OP_ID_ENTER: cyc_data = nor_seq_pkg::CMD_ID_READ;
              nor_seq_pkg::OP_PROGRAM: cyc_data = nor_seq_pkg::CMD_PROGRAM;
              nor_seq_pkg::OP_BYPASS_ENTER: cyc_data = nor_seq_pkg::CMD_BYPASS;
              default: begin
                cyc_addr = addr_r;
                cyc_data = nor_seq_pkg::CMD_BUF_LOAD;
              end
            endcase
          end
          6'd3: begin
            cyc_addr = addr_r;
            if (op_r == nor_seq_pkg::OP_ID_ENTER) begin
              cyc_read = 1'b1;
            end else if (op_r == nor_seq_pkg::OP_BUF_PROG) begin
              cyc_data = 16'(count_r);
            end else begin
              cyc_data = data_r;
            end
          end
          default: begin
            // Word is held from data_r once the stream has moved on
            cyc_addr = addr_r + 23'(step_r - 6'd4);
            cyc_data = (state_r == S_SETUP) ? buf_data : data_r;
            if (step_r == last_step_r) begin
              cyc_addr = addr_r;
              cyc_data = nor_seq_pkg::CMD_BUF_CONFIRM;
            end
          end
        endcase
      end
    endcase
  end

  wire buf_word = (op_r == nor_seq_pkg::OP_BUF_PROG) && step_r >= 6'd4 &&
    step_r != last_step_r;
  assign req_ready = (state_r == S_IDLE);
  assign buf_ready = (state_r == S_SETUP) && buf_word;

  ////////////////////////////////////////////////////////////////
  // Bus cycle engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      step_r <= 6'd0;
      last_step_r <= 6'd0;
      op_r <= 4'h0;
      addr_r <= 23'h000000;
      data_r <= 16'h0000;
      count_r <= 5'h00;
      cnt_r <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (req_valid && legal) begin
            op_r <= req_op;
            addr_r <= req_addr;
            data_r <= req_data;
            count_r <= req_count;
            step_r <= 6'd0;
            last_step_r <= seq_len - 6'd1;
            state_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          cnt_r <= '0;
          if (!buf_word || buf_valid) begin
            data_r <= buf_word ? buf_data : data_r;
            state_r <= cyc_read ? S_READ : S_STROBE;
          end
        end
        S_STROBE: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == nor_seq_pkg::CNT_W'(nor_seq_pkg::WE_PULSE_CYC - 1)) begin
            state_r <= S_HOLD;
          end
        end
        S_READ: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == nor_seq_pkg::CNT_W'(nor_seq_pkg::RD_ACCESS_CYC + 2))
          begin
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (step_r == last_step_r) begin
            state_r <= S_DONE;
          end else begin
            step_r <= step_r + 6'd1;
            state_r <= S_SETUP;
          end
        end
        S_DONE: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Pin drive; upper bits carry command codes as zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flash_addr <= 23'h000000;
      dq_out <= 16'h0000;
      dq_oe_n <= 1'b1;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
    end else begin
      flash_addr <= cyc_addr;
      dq_out <= cyc_data;
      // Enable and data outlive the write strobe by one clock
      dq_oe_n <= !(state_r == S_SETUP || state_r == S_STROBE ||
        state_r == S_HOLD) || cyc_read;
      ce_n <= !(state_r == S_STROBE || state_r == S_READ ||
        state_r == S_HOLD);
      oe_n <= !(state_r == S_READ);
      we_n <= !(state_r == S_STROBE);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read capture and mode tracking
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
      sync3_r <= 16'h0000;
      rsp_data <= 16'h0000;
      rsp_valid <= 1'b0;
    end else begin
      sync1_r <= dq_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      rsp_valid <= (state_r == S_DONE);
      if (state_r == S_READ && sync2_r == sync3_r) begin
        rsp_data <= sync3_r;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_ARRAY;
    end else if (state_r == S_DONE) begin
      case (op_r)
        nor_seq_pkg::OP_RESET: mode_r <= (mode_r == MODE_BYPASS ||
          mode_r == MODE_SUSP) ? mode_r : MODE_ARRAY;
        nor_seq_pkg::OP_ID_ENTER, nor_seq_pkg::OP_QUERY: mode_r <= MODE_ID;
        nor_seq_pkg::OP_BYPASS_ENTER: mode_r <= MODE_BYPASS;
        nor_seq_pkg::OP_BYPASS_EXIT: mode_r <= MODE_ARRAY;
        nor_seq_pkg::OP_SUSPEND: mode_r <= MODE_SUSP;
        nor_seq_pkg::OP_RESUME, nor_seq_pkg::OP_SET_EXIT: mode_r <= MODE_ARRAY;
        default: mode_r <= mode_r;
      endcase
    end
  end
  assign mode = mode_r;

  ////////////////////////////////////////////////////////////////
  // Checks
  AST_BYPASS_GUARD: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == S_IDLE && req_valid && mode_r == MODE_BYPASS &&
    req_op == nor_seq_pkg::OP_RESET |=> state_r == S_IDLE)
    else $error("reset accepted in bypass mode");
  AST_RESUME_GUARD: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == S_IDLE && req_valid && req_op == nor_seq_pkg::OP_RESUME &&
    mode_r != MODE_SUSP |=> state_r == S_IDLE)
    else $error("resume accepted outside suspend");
  AST_BYPASS_NEED: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == S_IDLE && req_valid && mode_r != MODE_BYPASS &&
    req_op == nor_seq_pkg::OP_BYPASS_PROG |=> state_r == S_IDLE)
    else $error("bypass program outside bypass mode");
  AST_BUF_LEN: assert property (@(posedge ref_clk) disable iff (rst)
    step_r <= 6'(nor_seq_pkg::BUF_SEQ_MAX_CYC - 1))
    else $error("buffer sequence too long");
  AST_READ_NO_WE: assert property (@(posedge ref_clk) disable iff (rst)
    !oe_n |-> we_n && dq_oe_n)
    else $error("write strobe during read");
  AST_ID_READ4: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == S_SETUP && op_r == nor_seq_pkg::OP_ID_ENTER &&
    step_r == 6'd3 |=> state_r == S_READ)
    else $error("id fourth cycle not a read");
  AST_WC_FIELD: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == S_STROBE && op_r == nor_seq_pkg::OP_BUF_PROG &&
    step_r == 6'd3 |-> dq_out == 16'(count_r))
    else $error("word count field wrong");
  AST_RESET_MODE: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == S_DONE && op_r == nor_seq_pkg::OP_RESET &&
    mode_r == MODE_ID |=> mode_r == MODE_ARRAY)
    else $error("reset did not leave id mode");
  AST_WE_WIDTH: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(we_n) |-> !we_n [*3])
    else $error("write pulse too short");
  AST_WE_RISE: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(we_n) |-> !ce_n && !dq_oe_n)
    else $error("enable or data released with write strobe");
  COV_PROG: cover property (@(posedge ref_clk)
    state_r == S_DONE && op_r == nor_seq_pkg::OP_PROGRAM);
  COV_BUF: cover property (@(posedge ref_clk)
    state_r == S_DONE && op_r == nor_seq_pkg::OP_BUF_PROG);
  COV_ID: cover property (@(posedge ref_clk) mode_r == MODE_ID);
endmodule : nor_flash_command_sequencer
`default_nettype wire

/* File: nor_flash_model.sv */
// Purpose: Behavioural NOR flash device facing the sequencer pins
// Assumes: Word mode; array and query reads use address bits 7..0
// Notes: No erase or protection logic; suspend and resume are ignored
`timescale 1ns/10ps
`default_nettype none
module nor_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h00c3 // Arbitrary value
) (
  // Pins
  input wire logic [22:0] addr,
  input wire logic [15:0] dq,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [15:0] dq_dev
);
  logic [15:0] mem [0:255];
  logic [15:0] val, last;
  logic [10:0] a;
  logic [7:0] c;
  int st = 0, md = 0, bcnt = 0;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    last = 16'h0000;
  end
  function automatic logic [15:0] qry(input logic [7:0] q);
    case (q)
      8'h10: qry = 16'h0051;
      8'h11: qry = 16'h0052;
      8'h12: qry = 16'h0059;
      8'h1f: qry = 16'h0006;
      8'h21: qry = 16'h0009;
      8'h22: qry = 16'h0013;
      8'h2a: qry = 16'h0006;
      default: qry = 16'h0000;
    endcase
  endfunction : qry
  ////////////////////////////////////////////////////////////////
  // Commands latched on the rising write strobe; b0 and 30 ignored,
  // as no erase ever runs here
  always @(posedge we_n) begin
    if (!ce_n) begin
      a = addr[10:0];
      c = dq[7:0];
      case (st)
        1: st = (a == 11'h2aa && c == 8'h55) ? 2 : 0;
        2: begin
          st = (c == 8'ha0) ? 4 : (c == 8'h25) ? 7 : 0;
          if (c == 8'h90) md = 1;
          if (c == 8'h20) md = 3;
        end
        4: begin
          mem[addr[7:0]] = dq;
          st = 0;
        end
        6: begin
          if (c == 8'h00) md = 0;
          st = 0;
        end
        7: begin
          bcnt = int'(dq[4:0]) + 1;
          st = 8;
        end
        8: begin
          mem[addr[7:0]] = dq;
          bcnt--;
          if (bcnt == 0) st = 9;
        end
        9: st = 0;
        default: begin
          // Only the bypass exit pair leaves bypass
          if (md != 3 && a == 11'h555 && c == 8'haa) st = 1;
          if (md != 3 && a == 11'h055 && c == 8'h98) md = 2;
          if (md != 3 && c == 8'hf0) md = 0;
          if (md == 3 && c == 8'ha0) st = 4;
          if (md == 3 && c == 8'h90) st = 6;
        end
      endcase
    end
  end
  // Released bus shows the inverse so a stale value never passes
  always @(*) begin
    if (!ce_n && !oe_n) begin
      case (md)
        1: val = ID_CODE;
        2: val = qry(addr[7:0]);
        default: val = mem[addr[7:0]];
      endcase
      last = val;
      dq_dev = val;
    end else dq_dev = ~last;
  end
endmodule : nor_flash_model
`default_nettype wire

/* File: nor_flash_command_sequencer_tb.sv */
// Purpose: Self-checking bench for the NOR command sequencer
// Assumes: Device model answers reads at once
// Notes: Write cycles are logged at the rising write strobe
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module nor_flash_command_sequencer_tb;
  localparam logic [15:0] ID_VAL = 16'h00c3; // Arbitrary value
  logic ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, buf_valid = 1'b0;
  logic req_ready, buf_ready, rsp_valid, dq_oe_n, ce_n, oe_n, we_n;
  logic [3:0] req_op = 4'h0;
  logic [22:0] req_addr = 23'h0, flash_addr;
  logic [15:0] req_data = 16'h0, buf_data, rsp_data, dq_out, dq_in, dq_dev;
  logic [4:0] req_count = 5'h0, bidx = 5'h0;
  logic [1:0] mode;
  logic [22:0] wa[$];
  logic [15:0] wd[$];
  int n_errors = 0, cmp_count = 0, cyc = 0;
  assign dq_in = !dq_oe_n ? dq_out : dq_dev;
  assign buf_data = {11'h2d0, bidx};
  nor_flash_command_sequencer i_dut (.ref_clk, .rst, .req_valid, .req_ready,
    .req_op, .req_addr, .req_data, .req_count, .buf_valid, .buf_ready,
    .buf_data, .rsp_valid, .rsp_data, .mode, .flash_addr, .dq_out, .dq_oe_n,
    .dq_in, .ce_n, .oe_n, .we_n);
  nor_flash_model #(.ID_CODE(ID_VAL)) i_dev (.addr(flash_addr), .dq(dq_in),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_dev(dq_dev));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge we_n) if (!ce_n) begin
    wa.push_back(flash_addr);
    wd.push_back(dq_in);
  end
  // Buffer source stalls every other cycle
  always @(negedge ref_clk) buf_valid <= ~buf_valid;
  always @(posedge ref_clk) if (buf_valid && buf_ready) bidx <= bidx + 5'h1;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic issue(input logic [3:0] op, input logic [22:0] ad,
    input logic [15:0] d, input logic [4:0] cn);
    int n;
    @(negedge ref_clk);
    {req_op, req_addr, req_data, req_count, req_valid} = {op, ad, d, cn, 1'b1};
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
    for (n = 0; n < 500 && rsp_valid !== 1'b1; n++) @(negedge ref_clk);
    `CHK("answer", 1'b1, rsp_valid)
  endtask : issue
  task automatic refuse(input logic [3:0] op);
    int n0;
    n0 = wa.size();
    @(negedge ref_clk);
    req_op = op;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    repeat (12) @(negedge ref_clk);
    `CHK("ready", 1'b1, req_ready)
    `CHK("writes", n0, wa.size())
  endtask : refuse
  task automatic unlock_ok;
    `CHK("u1", 27'h555aa, {wa[0][10:0], wd[0][7:0]})
    `CHK("u2", 27'h2aa55, {wa[1][10:0], wd[1][7:0]})
  endtask : unlock_ok
  ////////////////////////////////////////////////////////////////
  task automatic t_prog;
    wa.delete();
    wd.delete();
    issue(nor_seq_pkg::OP_PROGRAM, 23'h7fc012, 16'h1234, 5'h0);
    `CHK("nprog", 4, wa.size())
    unlock_ok();
    `CHK("cmd", 8'ha0, wd[2][7:0])
    `CHK("pa", 23'h7fc012, wa[3])
    `CHK("pd", 16'h1234, wd[3])
    issue(nor_seq_pkg::OP_READ, 23'h000012, 16'h0, 5'h0);
    `CHK("rd", 16'h1234, rsp_data)
    `CHK("nrd", 4, wa.size())
    $display("test prog done");
  endtask : t_prog
  task automatic t_id;
    wa.delete();
    wd.delete();
    issue(nor_seq_pkg::OP_ID_ENTER, 23'h000001, 16'h0, 5'h0);
    `CHK("idn", 3, wa.size())
    `CHK("id", ID_VAL, rsp_data)
    `CHK("idm", 2'h1, mode)
    issue(nor_seq_pkg::OP_RESET, 23'h0, 16'h0, 5'h0);
    `CHK("rm", 2'h0, mode)
    issue(nor_seq_pkg::OP_READ, 23'h000012, 16'h0, 5'h0);
    `CHK("ard", 16'h1234, rsp_data)
    $display("test id done");
  endtask : t_id
  task automatic t_query;
    logic [7:0] qa [7] = '{8'h10, 8'h11, 8'h12, 8'h1f, 8'h21, 8'h22, 8'h2a};
    logic [15:0] qd [7] = '{16'h0051, 16'h0052, 16'h0059, 16'h0006,
      16'h0009, 16'h0013, 16'h0006};
    issue(nor_seq_pkg::OP_QUERY, 23'h0, 16'h0, 5'h0);
    `CHK("qm", 2'h1, mode)
    for (int i = 0; i < 7; i++) begin
      issue(nor_seq_pkg::OP_READ, {15'h0, qa[i]}, 16'h0, 5'h0);
      `CHK("qry", qd[i], rsp_data)
    end
    issue(nor_seq_pkg::OP_RESET, 23'h0, 16'h0, 5'h0);
    issue(nor_seq_pkg::OP_READ, 23'h000012, 16'h0, 5'h0);
    `CHK("qx", 16'h1234, rsp_data)
    $display("test query done");
  endtask : t_query
  task automatic t_bypass;
    issue(nor_seq_pkg::OP_BYPASS_ENTER, 23'h0, 16'h0, 5'h0);
    `CHK("bm", 2'h2, mode)
    refuse(nor_seq_pkg::OP_RESET);
    refuse(nor_seq_pkg::OP_BUF_PROG);
    wa.delete();
    wd.delete();
    issue(nor_seq_pkg::OP_BYPASS_PROG, 23'h000020, 16'hbeef, 5'h0);
    `CHK("bn", 2, wa.size())
    issue(nor_seq_pkg::OP_BYPASS_EXIT, 23'h0, 16'h0, 5'h0);
    `CHK("bx", 16'h9000, {wd[2][7:0], wd[3][7:0]})
    `CHK("bxm", 2'h0, mode)
    issue(nor_seq_pkg::OP_READ, 23'h000020, 16'h0, 5'h0);
    `CHK("brd", 16'hbeef, rsp_data)
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_buf;
    wa.delete();
    wd.delete();
    issue(nor_seq_pkg::OP_BUF_PROG, 23'h000040, 16'h0, 5'h3);
    `CHK("nbuf", 9, wa.size())
    unlock_ok();
    `CHK("wc", 5'h3, wd[3][4:0])
    for (int i = 0; i < 4; i++) begin
      `CHK("ba", 23'h40 + 23'(i), wa[4 + i])
      `CHK("bd", 16'h5a00 + 16'(i), wd[4 + i])
    end
    `CHK("conf", 8'h29, wd[8][7:0])
    issue(nor_seq_pkg::OP_READ, 23'h000043, 16'h0, 5'h0);
    `CHK("brd", 16'h5a03, rsp_data)
    $display("test buffer done");
  endtask : t_buf
  task automatic t_susp;
    refuse(nor_seq_pkg::OP_RESUME);
    refuse(nor_seq_pkg::OP_BYPASS_PROG);
    issue(nor_seq_pkg::OP_SUSPEND, 23'h0, 16'h0, 5'h0);
    `CHK("sm", 2'h3, mode)
    issue(nor_seq_pkg::OP_RESET, 23'h0, 16'h0, 5'h0);
    `CHK("srm", 2'h3, mode)
    issue(nor_seq_pkg::OP_RESUME, 23'h0, 16'h0, 5'h0);
    `CHK("rm", 2'h0, mode)
    wa.delete();
    wd.delete();
    issue(nor_seq_pkg::OP_SET_EXIT, 23'h000100, 16'h0, 5'h0);
    `CHK("xn", 2, wa.size())
    `CHK("xd", 16'h9000, {wd[0][7:0], wd[1][7:0]})
    $display("test suspend done");
  endtask : t_susp
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    `CHK("mode0", 2'h0, mode)
    t_prog();
    t_id();
    t_query();
    t_bypass();
    t_buf();
    t_susp();
    tally_and_finish();
  end
endmodule : nor_flash_command_sequencer_tb
`default_nettype wire
